// ### rtl/ebu_top.sv
/*
  external bus unit: carries core accesses onto the external pins in
  multiplexed or demultiplexed, 8 or 16 bit modes (single-chip accesses end locally), with window
  decode, chip selects, ready waits and hold arbitration.
  assumes the core holds a request with its fields until ack; the ready and hold
  pin inputs are asynchronous and are synchronised here, data is sampled directly.
*/
`timescale 1ns/100ps
`default_nettype none
module ebu_top
  import ebu_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // configuration bits
  input wire logic [EBU_NWIN*EBU_SEL_W-1:0] window_address_select_in,
  input wire logic [EBU_CFG_W-1:0] default_bus_config_in,
  input wire logic [EBU_NWIN*EBU_CFG_W-1:0] window_bus_config_in,
  input wire logic [1:0] seg_size_in,
  input wire logic hold_arbitration_enable_in,
  input wire logic slave_mode_select_bit_in,
  input wire logic [7:0] pin_dir_in,
  input wire logic [7:0] pin_open_drain_in,
  // core request port
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire logic [EBU_ADDR_W-1:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  output logic ack_out,
  output logic [15:0] rdata_out,
  output logic busy_out,
  // external pins
  output logic [15:0] data_port_out,
  output logic [15:0] data_port_oe_out,
  input wire logic [15:0] data_port_in,
  output logic [15:0] address_port_out,
  output logic address_port_oe_out,
  output logic [7:0] seg_addr_out,
  output logic [7:0] seg_addr_oe_out,
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic bhe_n_out,
  input wire logic ready_n_in,
  output logic [7:0] port6_out,
  output logic [7:0] port6_oe_out,
  input wire logic hold_n_in,
  input wire logic hold_acknowledge_n_in
);
  ebu_win_if win();
  ebu_state_t state;
  logic [3:0] cnt;
  logic [EBU_CFG_W-1:0] cur_cfg;
  logic [EBU_NWIN:0] cur_hit;
  logic [2:0] rdy_sync, hold_sync, hold_acknowledge_sync;
  logic rdy_ok, hold_req, hold_acknowledge_in_lvl;

  ebu_win_dec u_dec (
    .win(win.dec),
    .sel_in(window_address_select_in),
    .cfg_in({window_bus_config_in, default_bus_config_in})
  );
  assign win.addr = req_addr_in;

  // three-stage synchronisers; change counts when stages two and three agree
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      rdy_sync <= 3'h7;
      hold_sync <= 3'h7;
      hold_acknowledge_sync <= 3'h7;
    end
    else if (ce_in)
    begin
      rdy_sync <= {rdy_sync[1:0], ready_n_in};
      hold_sync <= {hold_sync[1:0], hold_n_in};
      hold_acknowledge_sync <= {hold_acknowledge_sync[1:0], hold_acknowledge_n_in};
    end
  end

  // filtered levels, active high; kept until both late stages agree again
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      rdy_ok <= 1'b0;
      hold_req <= 1'b0;
      hold_acknowledge_in_lvl <= 1'b0;
    end
    else if (ce_in)
    begin
      if (rdy_sync[2] == rdy_sync[1])
        rdy_ok <= !rdy_sync[2];
      if (hold_sync[2] == hold_sync[1])
        hold_req <= !hold_sync[2];
      if (hold_acknowledge_sync[2] == hold_acknowledge_sync[1])
        hold_acknowledge_in_lvl <= !hold_acknowledge_sync[2];
    end
  end

  // decoded view of the active config; at the start edge the latched copy
  // is still the previous access, so the pins take the fresh decode then
  wire [EBU_CFG_W-1:0] act_cfg = (state == EBU_IDLE) ? win.cfg : cur_cfg;
  wire [EBU_NWIN:0] act_hit = (state == EBU_IDLE) ? win.hit_onehot : cur_hit;
  wire ebu_mode_t cur_mode = ebu_mode_t'(act_cfg[EBU_MODE_LSB +: 3]);
  wire is_mux = cur_mode == EBU_MUX16 || cur_mode == EBU_MUX8;
  wire is_8bit = cur_mode == EBU_MUX8 || cur_mode == EBU_DMX8;
  wire ebu_mode_t new_mode = ebu_mode_t'(win.cfg[EBU_MODE_LSB +: 3]);
  wire arb_on = hold_arbitration_enable_in;
  wire slave = arb_on && slave_mode_select_bit_in;
  // master grants on hold; slave owns bus only when acknowledge comes in
  wire give_up = arb_on && (slave ? !hold_acknowledge_in_lvl : hold_req);
  wire start = req_in && !ack_out && new_mode != EBU_SINGLE;
  wire local_done = req_in && !ack_out && new_mode == EBU_SINGLE;
  wire wait_done = cnt == EBU_CNT_RST && (!cur_cfg[EBU_RDY_BIT] || rdy_ok);

  // access sequencer: ale, strobe delay, strobe with waits, tri-state gap
  ebu_state_t next_state;
  logic [3:0] next_cnt;
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      EBU_IDLE:
        if (give_up)
          next_state = EBU_HELD;
        else if (start)
        begin
          next_state = EBU_ALE;
          next_cnt = {3'h0, win.cfg[EBU_ALE_BIT]};
        end
      EBU_ALE:
        if (cnt != EBU_CNT_RST)
          next_cnt = cnt - 4'h1;
        else if (cur_cfg[EBU_DLY_BIT])
          next_state = EBU_DELAY;
        else
        begin
          next_state = EBU_STROBE;
          next_cnt = cur_cfg[EBU_WAIT_LSB +: 4];
        end
      EBU_DELAY:
      begin
        next_state = EBU_STROBE;
        next_cnt = cur_cfg[EBU_WAIT_LSB +: 4];
      end
      EBU_STROBE:
        if (cnt != EBU_CNT_RST)
          next_cnt = cnt - 4'h1;
        else if (wait_done)
        begin
          next_state = EBU_TRIST;
          next_cnt = {3'h0, cur_cfg[EBU_TRI_BIT]};
        end
      EBU_TRIST:
        if (cnt != EBU_CNT_RST)
          next_cnt = cnt - 4'h1;
        else
          next_state = EBU_IDLE;
      EBU_HELD:
        if (!give_up)
          next_state = EBU_IDLE;
      default:
        next_state = EBU_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state <= EBU_IDLE;
      cnt <= EBU_CNT_RST;
    end
    else if (ce_in)
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // latch window result at access start so a moving address cannot glitch cs
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      cur_cfg <= EBU_CFG_RST;
      cur_hit <= '0;
    end
    else if (ce_in && state == EBU_IDLE && start && !give_up)
    begin
      cur_cfg <= win.cfg;
      cur_hit <= win.hit_onehot;
    end
  end

  // pin values for the next cycle
  wire in_access = next_state inside {EBU_ALE, EBU_DELAY, EBU_STROBE, EBU_TRIST};
  wire in_strobe = next_state == EBU_STROBE;
  wire held = next_state == EBU_HELD;
  wire addr_phase = next_state == EBU_ALE || next_state == EBU_DELAY;
  wire [15:0] wdata_lane = is_8bit ? {8'h00, req_wdata_in[7:0]} : req_wdata_in;
  wire [15:0] next_data = (is_mux && addr_phase) ? req_addr_in[15:0] : wdata_lane;
  wire drive_data = in_access && !held && ((is_mux && addr_phase) || (req_write_in && !addr_phase));
  wire [15:0] lane_oe = (is_mux && addr_phase) ? 16'hFFFF : (is_8bit ? 16'h00FF : 16'hFFFF);
  wire [3:0] seg_lines = (seg_size_in == EBU_SEG_16M) ? 4'h8 :
                         (seg_size_in == EBU_SEG_1M) ? 4'h4 :
                         (seg_size_in == EBU_SEG_256K) ? 4'h2 : 4'h0;
  wire [7:0] seg_mask = 8'hFF >> (4'h8 - seg_lines);
  wire [4:0] cs_n = in_access ? ~act_hit : EBU_CS_IDLE;
  // bus request when held off with an external access waiting
  wire bus_request_out = arb_on && held && req_in && new_mode != EBU_SINGLE;
  wire hold_acknowledge_drv = arb_on && !slave;
  wire [7:0] p6_val = {!bus_request_out, held ? 1'b0 : 1'b1, 1'b1, held ? EBU_CS_IDLE : cs_n};
  // controller owns 7 under arbitration and 6 as master only, never 5, and 4..0 unless held
  wire [7:0] own = {arb_on, hold_acknowledge_drv, 1'b0, {5{!held}}};
  wire [7:0] drv_en = own | (pin_dir_in & ~{arb_on, arb_on, arb_on, 5'h1F});
  wire [7:0] od_en = drv_en & ~(pin_open_drain_in & p6_val);
  wire done = (state == EBU_TRIST && cnt == EBU_CNT_RST) || local_done;

  // registered pins; data, address, segment and chip-select lines float while the bus is held away
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      data_port_out <= 16'h0000;
      data_port_oe_out <= 16'h0000;
      address_port_out <= 16'h0000;
      address_port_oe_out <= 1'b0;
      seg_addr_out <= 8'h00;
      seg_addr_oe_out <= 8'h00;
      ale_out <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      bhe_n_out <= 1'b1;
      port6_out <= 8'hFF;
      port6_oe_out <= 8'h00;
      ack_out <= 1'b0;
      rdata_out <= 16'h0000;
      busy_out <= 1'b0;
    end
    else if (ce_in)
    begin
      data_port_out <= next_data;
      data_port_oe_out <= drive_data ? lane_oe : 16'h0000;
      address_port_out <= req_addr_in[15:0];
      address_port_oe_out <= in_access && !is_mux;
      seg_addr_out <= req_addr_in[23:16] & seg_mask;
      seg_addr_oe_out <= in_access ? seg_mask : 8'h00;
      ale_out <= next_state == EBU_ALE;
      rd_n_out <= !(in_strobe && !req_write_in);
      wr_n_out <= !(in_strobe && req_write_in);
      bhe_n_out <= !(in_access && !req_byte_in && !is_8bit);
      port6_out <= p6_val;
      port6_oe_out <= od_en;
      ack_out <= done;
      if (state == EBU_STROBE && wait_done && !req_write_in)
        rdata_out <= is_8bit ? {8'h00, data_port_in[7:0]} : data_port_in;
      busy_out <= in_access;
    end
  end

  // checks
  ale_first_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ce_in && state == EBU_IDLE && start && !give_up) |=> ale_out)
    else $error("ale missing after access start");
  cs_onehot_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $countones(~port6_out[4:0]) <= 1)
    else $error("more than one chip select active");
  prio_4over3_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    win.hit_onehot[4] |-> !win.hit_onehot[3])
    else $error("window three not overridden by four");
  default_cfg_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    win.hit_onehot[0] |-> win.cfg == default_bus_config_in)
    else $error("default config not used outside windows");
  ready_wait_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ce_in && state == EBU_STROBE && cnt == EBU_CNT_RST && cur_cfg[EBU_RDY_BIT] && !rdy_ok)
    |=> state == EBU_STROBE)
    else $error("access ended without ready");
  float_held_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ce_in && state == EBU_HELD) |=> data_port_oe_out == 16'h0000 && !address_port_oe_out)
    else $error("bus driven while held");
  single_noext_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ce_in && local_done && state == EBU_IDLE) |=> ack_out && rd_n_out && wr_n_out)
    else $error("single-chip access reached the pins");
  seg_lines_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ce_in && seg_size_in == EBU_SEG_64K) |=> seg_addr_oe_out == 8'h00)
    else $error("segment lines driven in 64K space");
  no_arb_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ce_in && !hold_arbitration_enable_in) |=> port6_oe_out[7:5] == (pin_dir_in[7:5] & ~(pin_open_drain_in[7:5] & port6_out[7:5])))
    else $error("arbitration pins taken without enable");
  slave_hold_acknowledge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ce_in && hold_arbitration_enable_in && slave_mode_select_bit_in) |=> !port6_oe_out[6])
    else $error("acknowledge driven in slave mode");
  cov_write_c: cover property (@(posedge clk_in) !wr_n_out ##1 wr_n_out);
  cov_hold_c: cover property (@(posedge clk_in) state == EBU_HELD && bus_request_out);
  cov_wait_c: cover property (@(posedge clk_in) state == EBU_STROBE && !rdy_ok && cur_cfg[EBU_RDY_BIT]);
  cov_win4_c: cover property (@(posedge clk_in) busy_out && !port6_out[4]);
endmodule
`default_nettype wire

// ### rtl/ebu_pkg.sv
/*
  package of the external bus unit: bus modes, address-space sizes, window
  config field layout, access states and timing counts.
  assumes a 20 MHz core clock and nothing else.
*/
`default_nettype none
package ebu_pkg;

  // bus mode field of a bus config word
  typedef enum logic [2:0] {
    EBU_SINGLE   = 3'b000,
    EBU_DMX16    = 3'b001,
    EBU_MUX16    = 3'b010,
    EBU_MUX8     = 3'b011,
    EBU_DMX8     = 3'b100
  } ebu_mode_t;

  // address space restriction
  typedef enum logic [1:0] {
    EBU_SEG_16M  = 2'b00,
    EBU_SEG_1M   = 2'b01,
    EBU_SEG_256K = 2'b10,
    EBU_SEG_64K  = 2'b11
  } ebu_seg_t;

  typedef enum logic [2:0] {
    EBU_IDLE     = 3'b000,
    EBU_ALE      = 3'b001,
    EBU_DELAY    = 3'b010,
    EBU_STROBE   = 3'b011,
    EBU_TRIST    = 3'b100,
    EBU_HELD     = 3'b101
  } ebu_state_t;

  // bus config word layout: [2:0] mode, [6:3] wait states, [7] tri-state
  // time, [8] long ale, [9] strobe delay, [10] ready enable
  localparam int EBU_CFG_W = 11;
  localparam int EBU_MODE_LSB = 0;
  localparam int EBU_WAIT_LSB = 3;
  localparam int EBU_TRI_BIT = 7;
  localparam int EBU_ALE_BIT = 8;
  localparam int EBU_DLY_BIT = 9;
  localparam int EBU_RDY_BIT = 10;
  // window select layout: [11:0] base a23..a12, [15:12] size code
  localparam int EBU_SEL_W = 16;
  localparam int EBU_NWIN = 4;
  localparam int EBU_ADDR_W = 24;
  localparam logic [EBU_CFG_W-1:0] EBU_CFG_RST = 11'h000;
  localparam logic [3:0] EBU_CNT_RST = 4'h0;
  localparam logic [4:0] EBU_CS_IDLE = 5'h1F;

  // slack before a ready is trusted, derived from the clock rate
  localparam int EBU_CLK_MHZ = 20;
  localparam int EBU_RDY_SETUP_NS = 50;
  localparam int EBU_RDY_SETUP_CYC = (EBU_RDY_SETUP_NS * EBU_CLK_MHZ + 999) / 1000;

endpackage
`default_nettype wire

// ### rtl/ebu_win_if.sv
/*
  interface carrying the window decode result from the decoder to the top.
  assumes both ends share one clock domain; purely combinational content.
*/
`timescale 1ns/100ps
`default_nettype none
interface ebu_win_if;
  import ebu_pkg::*;
  logic [EBU_ADDR_W-1:0] addr;
  logic [EBU_NWIN:0] hit_onehot;
  logic [EBU_CFG_W-1:0] cfg;
  modport dec (input addr, output hit_onehot, output cfg);
  modport top (output addr, input hit_onehot, input cfg);
endinterface
`default_nettype wire

// ### rtl/ebu_win_dec.sv
/*
  window decoder: matches an address against four window selects and
  resolves priority, falling back to the default config.
  assumes selects and configs are held stable by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module ebu_win_dec
  import ebu_pkg::*;
(
  ebu_win_if.dec win,
  input wire logic [EBU_NWIN*EBU_SEL_W-1:0] sel_in,
  input wire logic [(EBU_NWIN+1)*EBU_CFG_W-1:0] cfg_in
);
  logic [EBU_NWIN-1:0] raw_hit;

  // per-window compare; size code masks low base bits, 4 KB granules
  genvar g;
  generate
    for (g = 0; g < EBU_NWIN; g++)
    begin : gen_win
      wire [11:0] base = sel_in[g*EBU_SEL_W +: 12];
      wire [3:0] size = sel_in[g*EBU_SEL_W+12 +: 4];
      wire [11:0] mask = 12'hFFF << size;
      wire enabled = base != 12'h000 || size != 4'h0;
      wire en_cfg = cfg_in[(g+1)*EBU_CFG_W +: 3] != EBU_SINGLE;
      assign raw_hit[g] = enabled && en_cfg && ((win.addr[23:12] & mask) == (base & mask));
    end
  endgenerate

  // 4 beats 3, 2 beats 1; pairs are taken as 4 > 3 > 2 > 1 overall
  wire w4 = raw_hit[3];
  wire w3 = raw_hit[2] && !w4;
  wire w2 = raw_hit[1] && !w4 && !w3;
  wire w1 = raw_hit[0] && !w4 && !w3 && !w2;
  wire w0 = !(w4 || w3 || w2 || w1);
  assign win.hit_onehot = {w4, w3, w2, w1, w0};
  assign win.cfg = w4 ? cfg_in[4*EBU_CFG_W +: EBU_CFG_W] :
                   w3 ? cfg_in[3*EBU_CFG_W +: EBU_CFG_W] :
                   w2 ? cfg_in[2*EBU_CFG_W +: EBU_CFG_W] :
                   w1 ? cfg_in[1*EBU_CFG_W +: EBU_CFG_W] :
                        cfg_in[0 +: EBU_CFG_W];
endmodule
`default_nettype wire

// ### dv/ebu_mem_model.sv
/*
  external memory partner: a byte array behind the bus pins, with an
  optional slow ready answer.
  assumes the bench tells it whether the bus is multiplexed.
*/
`timescale 1ns/100ps
`default_nettype none
module ebu_mem_model
(
  input wire logic clk_in,
  input wire logic mux_in,
  input wire logic [3:0] slow_in,
  input wire logic [15:0] dout_in,
  input wire logic [15:0] addr_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic bhe_n_in,
  output logic [15:0] dq_out,
  output logic ready_n_out,
  output logic [15:0] last_addr_out
);
  logic [7:0] mem [256];
  logic [3:0] cnt = 4'h0;
  logic [15:0] idle = 16'h0000;
  logic [7:0] a;
  // released lines flip every cycle, so a stale value never passes
  assign a = last_addr_out[7:0];
  assign dq_out = rd_n_in ? idle : {mem[a + 8'h01], mem[a]};
  assign ready_n_out = (rd_n_in & wr_n_in) | (cnt < slow_in);
  // address latch, write capture and ready delay count
  always @(posedge clk_in)
  begin
    idle <= ~dq_out;
    cnt <= (rd_n_in & wr_n_in) ? 4'h0 : cnt + ((cnt == 4'hF) ? 4'h0 : 4'h1);
    if (ale_in)
    begin
      last_addr_out <= mux_in ? dout_in : addr_in;
    end
    if (!wr_n_in)
    begin
      mem[a] <= dout_in[7:0];
      if (!bhe_n_in)
      begin
        mem[a + 8'h01] <= dout_in[15:8];
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/external_bus_controller_tb.sv
/*
  bench of the external bus unit: core accesses in every mode, window
  priority, timing fields, ready, segment lines and hold arbitration.
  assumes the memory partner model and the design package.
*/
`timescale 1ns/100ps
`default_nettype none
module external_bus_controller_tb;
  import ebu_pkg::*;
  logic clk_in, rstn_in, req_in, req_write_in, req_byte_in, hold_n_in, hold_acknowledge_n, hold_en, slave;
  logic ack_out, busy_out, ap_oe, ale, rd_n, wr_n, bhe_n, ready_n, mux, busy_seen;
  logic [63:0] sel;
  logic [10:0] dcfg;
  logic [43:0] wcfg;
  logic [1:0] seg;
  logic [3:0] slow;
  logic [4:0] cs_seen, e;
  logic [23:0] req_addr_in;
  logic [15:0] req_wdata_in, rdata_out, dp_out, dp_oe, dp_in, ap_out, dq, last_addr, rd_q, d;
  logic [7:0] seg_out, seg_oe, p6, p6_oe, seg_seen, seg_val, pdir, pod;
  logic [10:0] tcfg [4] = '{11'h019, 11'h081, 11'h101, 11'h201};
  logic [7:0] smask [4] = '{8'hFF, 8'h0F, 8'h03, 8'h00};
  int tdel [4] = '{3, 1, 1, 1};
  int tale [4] = '{1, 1, 2, 1};
  int err_count, check_count, cyc, ale_cnt, n0, n;

  // shared data wire: design wins where it drives
  assign dp_in = (dp_oe & dp_out) | (~dp_oe & dq);

  ebu_top i_ebu_top (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .window_address_select_in(sel), .default_bus_config_in(dcfg), .window_bus_config_in(wcfg),
    .seg_size_in(seg), .hold_arbitration_enable_in(hold_en), .slave_mode_select_bit_in(slave),
    .pin_dir_in(pdir), .pin_open_drain_in(pod), .req_in(req_in), .req_write_in(req_write_in),
    .req_byte_in(req_byte_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .ack_out(ack_out), .rdata_out(rdata_out), .busy_out(busy_out), .data_port_out(dp_out),
    .data_port_oe_out(dp_oe), .data_port_in(dp_in), .address_port_out(ap_out),
    .address_port_oe_out(ap_oe), .seg_addr_out(seg_out), .seg_addr_oe_out(seg_oe), .ale_out(ale),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .bhe_n_out(bhe_n), .ready_n_in(ready_n), .port6_out(p6),
    .port6_oe_out(p6_oe), .hold_n_in(hold_n_in), .hold_acknowledge_n_in(hold_acknowledge_n));

  ebu_mem_model i_ebu_mem_model (.clk_in(clk_in), .mux_in(mux), .slow_in(slow), .dout_in(dp_out),
    .addr_in(ap_out), .ale_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n), .bhe_n_in(bhe_n), .dq_out(dq),
    .ready_n_out(ready_n), .last_addr_out(last_addr));

  // 20 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // pin activity seen while a request is up
  always @(posedge clk_in)
  begin
    if (req_in)
    begin
      cs_seen <= cs_seen | ~p6[4:0];
      seg_seen <= seg_seen | seg_oe;
      if (|seg_oe)
        seg_val <= seg_out;
      ale_cnt <= ale_cnt + int'(ale);
      busy_seen <= busy_seen | busy_out;
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one core access; request held until ack, dropped on the next edge
  task automatic acc(input logic w, input logic b, input logic [23:0] a, input logic [15:0] wd);
    @(posedge clk_in);
    cs_seen = 5'h00;
    seg_seen = 8'h00;
    ale_cnt = 0;
    busy_seen = 1'b0;
    cyc = 0;
    req_in <= 1'b1;
    req_write_in <= w;
    req_byte_in <= b;
    req_addr_in <= a;
    req_wdata_in <= wd;
    do
    begin
      @(posedge clk_in);
      #1;
      cyc++;
    end
    while (ack_out !== 1'b1 && cyc < 300);
    chk(ack_out, 1'b1);
    rd_q = rdata_out;
    @(posedge clk_in);
    req_in <= 1'b0;
  endtask

  // write, read back, compare data, address and chip select
  task automatic rw(input logic b, input logic [23:0] a, input logic [15:0] wd, input logic [4:0] cs);
    acc(1'b1, b, a, wd);
    chk(cs_seen, cs);
    chk(busy_seen, 1'b1);
    acc(1'b0, b, a, 16'h0000);
    chk(b ? {8'h00, rd_q[7:0]} : rd_q, wd);
    chk(last_addr[7:0], a[7:0]);
  endtask

  task automatic stop_test;
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, well beyond the expected run
  initial
  begin
    #1000000;
    err_count++;
    stop_test;
  end

  // main sequence
  initial
  begin
    {rstn_in, req_in, req_write_in, req_byte_in, hold_en, slave, mux} = 7'h00;
    {hold_n_in, hold_acknowledge_n} = 2'b11;
    {pdir, pod} = 16'hFF00;
    {sel, wcfg, dcfg, seg, slow, req_addr_in, req_wdata_in} = '0;
    {err_count, check_count} = 0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1;
    chk(p6, 8'hFF);
    chk({dp_oe, ap_oe, rd_n, wr_n}, {16'h0000, 3'b011});
    acc(1'b0, 1'b0, 24'h000040, 16'h0000);
    chk(cs_seen, 5'h00);
    chk(busy_seen, 1'b0);
    // every external mode, bytes on the 8-bit paths
    for (int m = 1; m <= 4; m++)
    begin
      @(posedge clk_in);
      dcfg <= 11'(m);
      mux <= (m == 2) || (m == 3);
      d = (m > 2) ? 16'h00C0 + 16'(m) : 16'h5AC0 + 16'(m);
      rw(m > 2, 24'h000040 + 24'(2 * m), d, 5'h01);
    end
    // overlapping windows, every nonzero enable mask
    @(posedge clk_in);
    dcfg <= 11'h001;
    mux <= 1'b0;
    sel <= {4{16'h0001}};
    for (int k = 1; k < 16; k++)
    begin
      e = 5'h00;
      for (int g = 0; g < 4; g++)
        if (k[g])
          e = 5'h02 << g;
      @(posedge clk_in);
      for (int g = 0; g < 4; g++)
        wcfg[11 * g +: 11] <= k[g] ? 11'h001 : 11'h000;
      rw(1'b0, 24'h001020, 16'h1200 + 16'(k), e);
    end
    rw(1'b0, 24'h002060, 16'h3C3C, 5'h01);
    // timing fields against a baseline
    acc(1'b0, 1'b0, 24'h000042, 16'h0000);
    n0 = cyc;
    for (int t = 0; t < 4; t++)
    begin
      @(posedge clk_in);
      dcfg <= tcfg[t];
      acc(1'b0, 1'b0, 24'h000042, 16'h0000);
      chk(cyc, n0 + tdel[t]);
      chk(ale_cnt, tale[t]);
    end
    // slow device holds the access
    @(posedge clk_in);
    dcfg <= 11'h401;
    slow <= 4'h6;
    acc(1'b0, 1'b0, 24'h000042, 16'h0000);
    chk(cyc > n0 + 5, 1'b1);
    chk(rd_q, 16'h5AC1);
    // segment lines per space size
    @(posedge clk_in);
    dcfg <= 11'h001;
    slow <= 4'h0;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_in);
      seg <= 2'(s);
      acc(1'b0, 1'b0, 24'h5A0042, 16'h0000);
      chk(seg_seen, smask[s]);
      chk(seg_val & smask[s], 8'h5A & smask[s]);
    end
    // hold arbitration as master
    @(posedge clk_in);
    hold_en <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk(p6_oe[6], 1'b1);
    @(posedge clk_in);
    hold_n_in <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while (p6[6] !== 1'b0 && n < 20);
    chk({p6[6], dp_oe, ap_oe, p6_oe[4:0]}, 23'h0);
    fork
      acc(1'b0, 1'b0, 24'h000042, 16'h0000);
      begin
        repeat (15) @(posedge clk_in);
        #1;
        chk({p6[7], ack_out}, 2'b00);
        @(posedge clk_in);
        hold_n_in <= 1'b1;
      end
    join
    chk(cyc > 15, 1'b1);
    chk(rd_q, 16'h5AC1);
    // slave mode: acknowledge pin turns input
    @(posedge clk_in);
    slave <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    chk(p6_oe[6], 1'b0);
    @(posedge clk_in);
    hold_acknowledge_n <= 1'b0;
    acc(1'b0, 1'b0, 24'h000042, 16'h0000);
    chk(rd_q, 16'h5AC1);
    // shared pins: open drain lets high levels go, inputs float
    @(posedge clk_in);
    {hold_en, slave} <= 2'b00;
    pod <= 8'hFF;
    repeat (2) @(posedge clk_in);
    #1;
    chk(p6_oe, 8'h00);
    @(posedge clk_in);
    {pdir, pod} <= 16'h0000;
    repeat (2) @(posedge clk_in);
    #1;
    chk(p6_oe, 8'h1F);
    stop_test;
  end
endmodule
`default_nettype wire
